// ==== src/ext_mode_config.v ====
// Extended mode register decode and burst column order generator.
// Assumes command pins come from logic on ref_clk, sampled at its rising edge.
// Assumes selfRefresh and base_mode_reg are same-clock levels from elsewhere.
// Assumes the data and strobe pin drivers honour outputsOn.
`timescale 1ns/1ps
`include "ext_mode_map.vh"

module ext_mode_config (
  input wire ref_clk,
  input wire rst_b,
  input wire cke,
  input wire csB,
  input wire rasB,
  input wire casB,
  input wire weB,
  input wire [1:0] bank,
  input wire [12:0] addr,
  input wire selfRefresh,
  input wire [12:0] base_mode_reg,
  input wire [2:0] burstStart,
  output reg [12:0] ext_mode_reg_first,
  output reg [12:0] ext_mode_reg_second,
  output reg dllOn,
  output reg [1:0] driveStrength,
  output reg [2:0] added_latency,
  output reg [1:0] die_termination,
  output reg [2:0] driver_calibration,
  output reg strobeDiffOff,
  output reg outputsOn,
  output reg hot_refresh_rate_en,
  output reg [3:0] bankRefreshMask,
  output reg [23:0] burstOrder
);

// ==========================================
// Declarations
// Command decode
wire loadCmd;
wire loadFirst;
wire loadSecond;
wire calAdjust;

// Register next values
reg [12:0] next_first;
reg [12:0] next_second;
reg [2:0] refreshSel;
reg [3:0] next_mask;
reg [3:0] next_gatedMask;

// Field next values
reg next_dllOn;
reg [1:0] next_drive;
reg [2:0] next_latency;
reg [1:0] next_term;
reg [2:0] next_cal;
reg next_strobeOff;
reg next_outputsOn;
reg next_hot;

// Burst order
wire [23:0] next_order;
wire interleave;
wire eightBeats;

// ==========================================
// Command decode
// A load needs cke high at the same edge; low cke means no command
assign loadCmd = cke & ~csB & ~rasB & ~casB & ~weB; // [R22]
assign loadFirst = loadCmd & (bank == `BANK_FIRST); // [R4]
assign loadSecond = loadCmd & (bank == `BANK_SECOND); // [R14]
// Base and third register codes load nothing here [R19]
assign calAdjust = (addr[`CAL_HI:`CAL_LO] == `CAL_ADJUST); // [R11]

// ==========================================
// Next register contents
always @* begin
  next_first = ext_mode_reg_first;
  if (loadFirst) begin
    next_first = addr; // [R4]
    if (calAdjust) begin
      // Adjust must not disturb the latency already in use
      next_first[`LAT_HI:`LAT_LO] = ext_mode_reg_first[`LAT_HI:`LAT_LO]; // [R11]
    end
  end
end

always @* begin
  next_second = ext_mode_reg_second;
  if (loadSecond) begin
    next_second = addr; // [R14]
  end
end

// ==========================================
// Mode register storage
always @(posedge ref_clk) begin
  if (!rst_b) begin
    // No defined reset value; zero keeps every field known
    ext_mode_reg_first <= `REG_RESET;
  end else begin
    ext_mode_reg_first <= next_first;
  end
end

always @(posedge ref_clk) begin
  if (!rst_b) begin
    ext_mode_reg_second <= `REG_RESET;
  end else begin
    ext_mode_reg_second <= next_second;
  end
end

// ==========================================
// Refreshed bank set
// Bit n of the mask set means bank n keeps its refresh
always @* begin
  refreshSel = ext_mode_reg_second[`REFRESH_SEL_HI:`REFRESH_SEL_LO];
  case (refreshSel) // [R16]
    `SEL_ALL: next_mask = `MASK_ALL;
    `SEL_LOW_HALF: next_mask = `MASK_LOW_HALF;
    `SEL_LOW_QUARTER: next_mask = `MASK_LOW_QUARTER;
    `SEL_HIGH_THREE: next_mask = `MASK_HIGH_THREE;
    `SEL_HIGH_HALF: next_mask = `MASK_HIGH_HALF;
    `SEL_HIGH_QUARTER: next_mask = `MASK_HIGH_QUARTER;
    // Reserved codes refresh everything rather than risk data
    default: next_mask = `MASK_ALL;
  endcase
end

// ==========================================
// Delay loop enable
always @* begin
  // Self refresh drops the loop with no command from the controller
  next_dllOn = ~ext_mode_reg_first[`DLL_OFF_BIT] & ~selfRefresh; // [R8]
end

always @(posedge ref_clk) begin
  if (!rst_b) begin
    dllOn <= `BIT_RESET;
  end else begin
    dllOn <= next_dllOn;
  end
end

// ==========================================
// Drive strength
always @* begin
  next_drive = {ext_mode_reg_first[`RDQS_BIT], ext_mode_reg_first[`DRIVE_BIT]}; // [R23]
end

always @(posedge ref_clk) begin
  if (!rst_b) begin
    driveStrength <= `PAIR_RESET;
  end else begin
    driveStrength <= next_drive;
  end
end

// ==========================================
// Added latency
always @* begin
  next_latency = ext_mode_reg_first[`LAT_HI:`LAT_LO]; // [R23]
end

always @(posedge ref_clk) begin
  if (!rst_b) begin
    added_latency <= `TRIPLE_RESET;
  end else begin
    added_latency <= next_latency;
  end
end

// ==========================================
// Die termination
always @* begin
  next_term = {ext_mode_reg_first[`TERM_HI_BIT], ext_mode_reg_first[`TERM_LO_BIT]}; // [R23]
end

always @(posedge ref_clk) begin
  if (!rst_b) begin
    die_termination <= `PAIR_RESET;
  end else begin
    die_termination <= next_term;
  end
end

// ==========================================
// Driver calibration
// Adjust code shows here as written; its latency hold lives in the load path
always @* begin
  next_cal = ext_mode_reg_first[`CAL_HI:`CAL_LO]; // [R23]
end

always @(posedge ref_clk) begin
  if (!rst_b) begin
    driver_calibration <= `TRIPLE_RESET;
  end else begin
    driver_calibration <= next_cal;
  end
end

// ==========================================
// Complementary strobe off
always @* begin
  next_strobeOff = ext_mode_reg_first[`STROBE_OFF_BIT]; // [R23]
end

always @(posedge ref_clk) begin
  if (!rst_b) begin
    strobeDiffOff <= `BIT_RESET;
  end else begin
    strobeDiffOff <= next_strobeOff;
  end
end

// ==========================================
// Output enable
// Low releases data and every strobe, complementary ones too
always @* begin
  next_outputsOn = ~ext_mode_reg_first[`OUT_OFF_BIT]; // [R13]
end

always @(posedge ref_clk) begin
  if (!rst_b) begin
    outputsOn <= `BIT_RESET;
  end else begin
    outputsOn <= next_outputsOn;
  end
end

// ==========================================
// Hot refresh rate
// Stored as written; only the refresh timer elsewhere acts on it
always @* begin
  next_hot = ext_mode_reg_second[`HOT_BIT]; // [R15]
end

always @(posedge ref_clk) begin
  if (!rst_b) begin
    hot_refresh_rate_en <= `BIT_RESET;
  end else begin
    hot_refresh_rate_en <= next_hot;
  end
end

// ==========================================
// Refresh mask
// Unselected banks skip refresh only while self refreshing
always @* begin
  next_gatedMask = selfRefresh ? next_mask : `MASK_ALL; // [R17]
end

always @(posedge ref_clk) begin
  if (!rst_b) begin
    bankRefreshMask <= `MASK_ALL;
  end else begin
    bankRefreshMask <= next_gatedMask;
  end
end

// ==========================================
// Burst column order, beat 0 in the low three bits
assign interleave = base_mode_reg[`BASE_TYPE_BIT]; // [R21]
assign eightBeats = (base_mode_reg[`BASE_LEN_HI:`BASE_LEN_LO] == `LEN_EIGHT);
// Four-beat bursts keep the upper column bit; upper beats still filled

genvar beat;
generate
  for (beat = 0; beat < `BEATS; beat = beat + 1) begin : gBeat
    localparam [31:0] BEAT_NUM = beat;
    wire [2:0] idx;
    wire [2:0] rotSum;
    wire [1:0] rot;
    wire [2:0] seqCol;
    wire [2:0] xorCol;
    wire [2:0] col4;

    assign idx = BEAT_NUM[2:0];
    // Carry out of the low two bits is dropped on purpose: nibble wrap
    assign rotSum = {`PAD_BIT, burstStart[1:0]} + {`PAD_BIT, idx[1:0]};
    assign rot = rotSum[1:0];

    assign seqCol = {burstStart[2] ^ idx[2], rot}; // [R2]
    assign xorCol = burstStart ^ idx; // [R3]
    assign col4 = interleave ? {burstStart[2], burstStart[1:0] ^ idx[1:0]}
                             : {burstStart[2], rot}; // [R1]

    assign next_order[`COL_W*beat +: `COL_W] = eightBeats ?
                                               (interleave ? xorCol : seqCol) : col4;
  end
endgenerate

// ==========================================
// Order register
// Registered so the order settles a clean cycle after the start column
always @(posedge ref_clk) begin
  if (!rst_b) begin
    burstOrder <= `ORDER_RESET;
  end else begin
    burstOrder <= next_order;
  end
end

endmodule // ext_mode_config

// ==== src/ext_mode_map.vh ====
// Constants for the extended mode register and burst order block.
// Assumes command pins are already on ref_clk and all bank state lives elsewhere.
// What this block does and what it expects of the controller
// [R1] Four-beat order: rotate or XOR low bits
// [R2] Eight-beat sequential wraps inside starting nibble
// [R3] Eight-beat interleaved: start XOR beat index
// [R4] First register loads on load command, bank 01
// [R5] Controller loads only when idle, waits cycle
// [R6] Controller programs both registers at initialization
// [R7] Controller keeps delay loop enabled normally
// [R8] Delay loop off in self refresh, back after
// [R9] Controller waits 200 clocks before read
// [R10] Controller writes zero to bit 11
// [R11] Calibration adjust keeps previous added latency
// [R12] Controller exits calibration with bits cleared
// [R13] Output disable releases data and strobe pins
// [R14] Second register loads on load command, bank 10
// [R15] Bit 7 selects hot refresh rate
// [R16] Low three bits decode refreshed bank set
// [R17] Self refresh refreshes only selected banks
// [R18] Controller writes zero to reserved bits
// [R19] Load command to bank 11 has no effect
// [R20] Controller issues only specified operations
// [R21] Base register bit 3 picks burst type
// [R22] Commands decoded from strobes at rising edge
// [R23] Other first-register fields in customary places
`ifndef EXT_MODE_MAP_VH
`define EXT_MODE_MAP_VH
`define ADDR_W 13
`define BANK_FIRST 2'h1
`define BANK_SECOND 2'h2
`define BANK_THIRD 2'h3
`define BASE_TYPE_BIT 3
`define BASE_LEN_HI 2
`define BASE_LEN_LO 0
`define LEN_EIGHT 3'h3
`define DLL_OFF_BIT 0
`define DRIVE_BIT 1
`define TERM_LO_BIT 2
`define TERM_HI_BIT 6
`define LAT_HI 5
`define LAT_LO 3
`define CAL_HI 9
`define CAL_LO 7
`define CAL_ADJUST 3'h4
`define STROBE_OFF_BIT 10
`define RDQS_BIT 11
`define OUT_OFF_BIT 12
`define HOT_BIT 7
`define REFRESH_SEL_HI 2
`define REFRESH_SEL_LO 0
`define SEL_ALL 3'h0
`define SEL_LOW_HALF 3'h1
`define SEL_LOW_QUARTER 3'h2
`define SEL_HIGH_THREE 3'h4
`define SEL_HIGH_HALF 3'h5
`define SEL_HIGH_QUARTER 3'h6
`define MASK_ALL 4'hf
`define MASK_LOW_HALF 4'h3
`define MASK_LOW_QUARTER 4'h1
`define MASK_HIGH_THREE 4'he
`define MASK_HIGH_HALF 4'hc
`define MASK_HIGH_QUARTER 4'h8
`define BEATS 8
`define COL_W 3
`define PAD_BIT 1'h0
`define REG_RESET 13'h0000
`define BIT_RESET 1'h0
`define PAIR_RESET 2'h0
`define TRIPLE_RESET 3'h0
`define ORDER_RESET 24'h00_0000
`endif

// ==== sim/ctl_model.sv ====
// Controller model: issues mode loads on the command pins.
// Assumes it alone drives those pins.
`timescale 1ns/1ps
module ctl_model (
  input wire ref_clk,
  output logic cke,
  output logic [3:0] cmd,
  output logic [1:0] bank,
  output logic [12:0] addr
);
  // ======
  // Loads; a released bus shows the inverse so stale data is never read
  // Issues no reads at all, so the lock wait is kept by construction
  initial {cke, cmd, bank, addr} = {1'h1, 4'hf, 2'h0, 13'h0000};
  task automatic ld(input logic [1:0] b, input logic [12:0] a);
    @(negedge ref_clk) {cmd, bank, addr} = {4'h0, b, a};
    @(negedge ref_clk) {cmd, addr} = {4'hf, ~a};
  endtask
  // Same strobes with cke low: the device must not take it
  task automatic ld_off(input logic [1:0] b, input logic [12:0] a);
    @(negedge ref_clk) {cke, cmd, bank, addr} = {1'h0, 4'h0, b, a};
    @(negedge ref_clk) {cke, cmd, addr} = {1'h1, 4'hf, ~a};
  endtask
endmodule // ctl_model

// ==== sim/ext_mode_props.sv ====
// Port checks for the extended mode block.
// Assumes one clock; bound to every design instance below.
`timescale 1ns/1ps
module ext_mode_props (
  input wire ref_clk,
  input wire rst_b,
  input wire cke,
  input wire csB,
  input wire rasB,
  input wire casB,
  input wire weB,
  input wire selfRefresh,
  input wire dllOn,
  input wire outputsOn,
  input wire hot_refresh_rate_en,
  input wire [1:0] bank,
  input wire [2:0] burstStart,
  input wire [3:0] bankRefreshMask,
  input wire [12:0] addr,
  input wire [12:0] ext_mode_reg_first,
  input wire [12:0] ext_mode_reg_second,
  input wire [23:0] burstOrder
);
  // ======
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire ld;
  assign ld = cke & ~csB & ~rasB & ~casB & ~weB;
  first_load_a: assert property (ld && bank == 2'h1 && addr[9:7] != 3'h4
    |=> ext_mode_reg_first == $past(addr)) else $error("first load lost");
  adjust_keep_a: assert property (ld && bank == 2'h1 && addr[9:7] == 3'h4
    |=> ext_mode_reg_first[5:3] == $past(ext_mode_reg_first[5:3])
      && ext_mode_reg_first[9:7] == 3'h4) else $error("adjust moved latency");
  second_load_a: assert property (ld && bank == 2'h2
    |=> ext_mode_reg_second == $past(addr)) else $error("second load lost");
  spare_load_a: assert property (ld && bank == 2'h3
    |=> $stable(ext_mode_reg_first) && $stable(ext_mode_reg_second)) else $error("spare");
  cke_gate_a: assert property (!cke
    |=> $stable(ext_mode_reg_first) && $stable(ext_mode_reg_second)) else $error("cke low load");
  dll_follow_a: assert property (1'h1 |=> dllOn ==
    (!$past(ext_mode_reg_first[0]) && !$past(selfRefresh))) else $error("dll wrong");
  out_off_a: assert property (1'h1 |=>
    outputsOn == !$past(ext_mode_reg_first[12])) else $error("outputs wrong");
  hot_rate_a: assert property (1'h1 |=>
    hot_refresh_rate_en == $past(ext_mode_reg_second[7])) else $error("hot rate");
  awake_mask_a: assert property (!selfRefresh |=> bankRefreshMask == 4'hf)
    else $error("mask awake");
  burst_head_a: assert property (1'h1 |=> burstOrder[2:0] == $past(burstStart))
    else $error("beat zero");
  cover property (ld && bank == 2'h3);
  cover property (selfRefresh && bankRefreshMask != 4'hf);
  cover property (ld && bank == 2'h1 && addr[9:7] == 3'h4);
endmodule // ext_mode_props
bind ext_mode_config ext_mode_props props (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .cke(cke),
  .csB(csB),
  .rasB(rasB),
  .casB(casB),
  .weB(weB),
  .selfRefresh(selfRefresh),
  .dllOn(dllOn),
  .outputsOn(outputsOn),
  .hot_refresh_rate_en(hot_refresh_rate_en),
  .bank(bank),
  .burstStart(burstStart),
  .bankRefreshMask(bankRefreshMask),
  .addr(addr),
  .ext_mode_reg_first(ext_mode_reg_first),
  .ext_mode_reg_second(ext_mode_reg_second),
  .burstOrder(burstOrder)
);

// ==== sim/ext_mode_config_bench.sv ====
// Bench: controller model loads registers, tasks judge outputs.
// Assumes the checker binds itself.
`timescale 1ns/1ps
module ext_mode_config_bench;
  // ======
  // Harness
  logic ref_clk = 0, rst_b = 0, selfRefresh = 0;
  logic [12:0] base_mode_reg = 13'h0000;
  logic [2:0] burstStart = 3'h0;
  wire cke, csB, rasB, casB, weB, dllOn, strobeDiffOff, outputsOn, hot_refresh_rate_en;
  wire [1:0] bank, driveStrength, die_termination;
  wire [2:0] added_latency, driver_calibration;
  wire [3:0] bankRefreshMask;
  wire [12:0] addr, ext_mode_reg_first, ext_mode_reg_second;
  wire [23:0] burstOrder;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // Ceiling well above the hundred or so cycles the tasks take
  localparam int LIMIT = 2000;
  // Expected refreshed banks per select code, code c at bits 4c+3:4c
  localparam logic [31:0] MASKS = 32'hf8ce_f13f;
  ext_mode_config dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .cke(cke),
    .csB(csB),
    .rasB(rasB),
    .casB(casB),
    .weB(weB),
    .bank(bank),
    .addr(addr),
    .selfRefresh(selfRefresh),
    .base_mode_reg(base_mode_reg),
    .burstStart(burstStart),
    .ext_mode_reg_first(ext_mode_reg_first),
    .ext_mode_reg_second(ext_mode_reg_second),
    .dllOn(dllOn),
    .driveStrength(driveStrength),
    .added_latency(added_latency),
    .die_termination(die_termination),
    .driver_calibration(driver_calibration),
    .strobeDiffOff(strobeDiffOff),
    .outputsOn(outputsOn),
    .hot_refresh_rate_en(hot_refresh_rate_en),
    .bankRefreshMask(bankRefreshMask),
    .burstOrder(burstOrder)
  );
  ctl_model ctl (.ref_clk(ref_clk), .cke(cke), .cmd({csB, rasB, casB, weB}), .bank(bank),
    .addr(addr));
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: run limit reached", $time);
      conclude();
    end
  end
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task t_regs;
    ctl.ld(2'h2, 13'h0085);
    ctl.ld(2'h1, 13'h1028);
    ctl.ld(2'h3, 13'h0001);
    @(negedge ref_clk);
    chk({ext_mode_reg_first, hot_refresh_rate_en, outputsOn, dllOn}, {13'h1028, 3'h5});
    chk({ext_mode_reg_second, added_latency}, {13'h0085, 3'h5});
    ctl.ld(2'h1, 13'h0200);
    @(negedge ref_clk);
    chk({added_latency, driver_calibration}, {3'h5, 3'h4});
    ctl.ld(2'h1, 13'h0028);
    @(negedge ref_clk);
    chk({outputsOn, driver_calibration}, {1'h1, 3'h0});
    ctl.ld(2'h1, 13'h0447);
    @(negedge ref_clk);
    chk({driveStrength, die_termination, strobeDiffOff, dllOn}, {2'h1, 2'h3, 2'h2});
    ctl.ld_off(2'h2, 13'h0007);
    @(negedge ref_clk);
    chk(ext_mode_reg_second, 13'h0085);
    ctl.ld(2'h1, 13'h0028);
    $display("regs done");
  endtask
  task t_partial_array_refresh_sel;
    for (int c = 0; c < 8; c++) begin
      ctl.ld(2'h2, {10'h000, c[2:0]});
      selfRefresh = 1;
      repeat (2) @(negedge ref_clk);
      chk({bankRefreshMask, dllOn}, {MASKS[4*c +: 4], 1'h0});
      selfRefresh = 0;
    end
    @(negedge ref_clk);
    chk({bankRefreshMask, dllOn}, {4'hf, 1'h1});
    $display("refresh done");
  endtask
  task t_reset;
    rst_b = 0;
    @(negedge ref_clk);
    chk({bankRefreshMask, dllOn, outputsOn, ext_mode_reg_first}, {4'hf, 2'h0, 13'h0000});
    chk({hot_refresh_rate_en, ext_mode_reg_second}, {1'h0, 13'h0000});
    chk(burstOrder, 24'h00_0000);
    rst_b = 1;
    ctl.ld(2'h2, 13'h0080);
    @(negedge ref_clk);
    chk({hot_refresh_rate_en, ext_mode_reg_second}, {1'h1, 13'h0080});
    $display("reset done");
  endtask
  task t_burst;
    logic [23:0] e;
    for (int i = 0; i < 32; i++) begin
      {base_mode_reg, burstStart} = {9'h000, i[4], 2'h1, i[3], i[2:0]};
      for (int k = 0; k < 8; k++)
        e[3*k +: 3] = {i[2] ^ (i[3] & k[2]), i[4] ? i[1:0] ^ k[1:0] : i[1:0] + k[1:0]};
      @(negedge ref_clk);
      chk(burstOrder & {{12{i[3]}}, 12'hfff}, e & {{12{i[3]}}, 12'hfff});
    end
    {base_mode_reg, burstStart} = {13'h0003, 3'h5};
    @(negedge ref_clk);
    chk(burstOrder, 24'h0d_19f5);
    {base_mode_reg, burstStart} = {13'h000b, 3'h6};
    @(negedge ref_clk);
    chk(burstOrder, 24'h21_ab3e);
    {base_mode_reg, burstStart} = {13'h0002, 3'h3};
    @(negedge ref_clk);
    chk(burstOrder & 24'h00_0fff, 24'h00_0443);
    $display("burst done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_b = 1;
    t_regs();
    t_partial_array_refresh_sel();
    t_burst();
    t_reset();
    conclude();
  end
endmodule // ext_mode_config_bench
